//--- logic/gpio_exp_pkg.sv
package gpio_exp_pkg;

    localparam int BANK_COUNT = 5;
    localparam int BANK_WIDTH = 8;
    localparam int PIN_COUNT = BANK_COUNT * BANK_WIDTH;
    localparam int STRAP_COUNT = 3;

    // Register group bases; bits 5:3 pick the group, bits 2:0 the bank
    localparam logic [5:0] INPUT_BASE = 6'h00;
    localparam logic [5:0] OUTPUT_BASE = 6'h08;
    localparam logic [5:0] INVERT_BASE = 6'h10;
    localparam logic [5:0] DIRECTION_BASE = 6'h18;
    localparam logic [5:0] MASK_BASE = 6'h20;
    localparam logic [2:0] LAST_BANK = 3'h4;

    // Command pointer fields
    localparam int STEP_FLAG_BIT = 7;
    localparam int GROUP_MSB = 5;
    localparam int GROUP_LSB = 3;
    localparam int BANK_MSB = 2;

    // Reset values
    localparam logic [7:0] POINTER_RESET = 8'h80;
    localparam logic [7:0] OUTPUT_RESET = 8'h00;
    localparam logic [7:0] INVERT_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hff;
    localparam logic [7:0] MASK_RESET = 8'hff;

    // Upper four bits of the seven-bit slave address; value is arbitrary
    localparam logic [3:0] SLAVE_ADDR_HI_DEFAULT = 4'h2;

    typedef enum logic [1:0] {
        EVT_CMD,
        EVT_RD_START,
        EVT_RD_NEXT
    } link_evt_t;

    typedef enum logic [2:0] {
        LS_ADDR,
        LS_ADDR_ACK,
        LS_CMD,
        LS_CMD_ACK,
        LS_WR,
        LS_WR_ACK,
        LS_RD,
        LS_RD_ACK
    } link_state_t;

endpackage

//--- logic/gpio_expander.sv
// Operation
// - Forty pins as five banks of eight
// - Each pin individually input or output
// - Outputs change at acknowledge of the byte
// - Per-pin mask blocks change interrupts
// - Per-pin read inversion toward the master
// - Alert low on unmasked input change
// - Output enable high floats output pins
// - Reset restores defaults, all pins inputs
// - Three straps match low address bits
// - Slave works at standard and fast rates
// - Direction bit one reads, zero writes
// - First written byte loads command pointer
// - Six low pointer bits select register
// - Step flag advances bank after each byte; a refused input write holds it
// - Skip reserved banks, wrap after four
// - Step flag clear holds the pointer
// - Pointer resets to step flag only
// - Acknowledge writable bytes, refuse input writes
// - Group bases and bank field layout
// - Input registers show pins xor inversion
// - Direction zero output, resets to ones
// - Mask zero enables interrupt, resets ones
`timescale 1ns/1ps
module gpio_expander
    import gpio_exp_pkg::*;
#(
    parameter logic [3:0] SLAVE_ADDR_HI = SLAVE_ADDR_HI_DEFAULT
)
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Serial link, clock of its own domain
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Address straps
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    // Output enable, active low
    input wire logic output_enable_n,
    // Port pins
    input wire logic [PIN_COUNT-1:0] port_pin_i,
    output logic [PIN_COUNT-1:0] port_pin_o,
    output logic [PIN_COUNT-1:0] port_pin_oe_n,
    // Alert, open drain
    output logic alert_o,
    output logic alert_oe_n
);

    localparam int SYNC_WIDTH = PIN_COUNT + STRAP_COUNT + 3;

    link_if lnk();

    logic [SYNC_WIDTH-1:0] sync_meta;
    logic [SYNC_WIDTH-1:0] sync_q;
    logic [PIN_COUNT-1:0] pin_level;
    logic [STRAP_COUNT-1:0] strap_level;
    logic scl_s;
    logic sda_s;
    logic oe_n_s;
    logic sda_prev;
    logic bus_start;
    logic bus_stop;
    logic frame_clr;

    logic [1:0] evt_meta;
    logic [1:0] evt_sync;
    logic [1:0] evt_prev;
    logic cmd_fire;
    logic rd_fire;
    logic rd_next_fire;
    logic wr_fire;

    logic [7:0] command_pointer;
    logic [7:0] next_command_pointer;
    logic [7:0] output_drive_regs [BANK_COUNT];
    logic [7:0] read_invert_regs [BANK_COUNT];
    logic [7:0] direction_regs [BANK_COUNT];
    logic [7:0] change_mask_regs [BANK_COUNT];
    logic [7:0] input_level_regs [BANK_COUNT];
    logic [7:0] last_read [BANK_COUNT];
    logic [7:0] pin_bank [BANK_COUNT];
    logic [7:0] read_snapshot;
    logic wr_refused;
    logic snap_req;
    logic snap_rd;
    logic primed;
    logic alert;
    logic change_seen;

    // Link logic runs on the serial clock; the core only sees toggles and held bytes
    serial_slave #(
        .SLAVE_ADDR_HI(SLAVE_ADDR_HI)
    ) u_link (
        .scl(scl),
        .sda_i(sda_i),
        .frame_clr(frame_clr),
        .lnk(lnk.link)
    );

    // Every pin-level input passes two flops before use in the core; the link takes scl and sda_i directly
    always_ff @(posedge clk)
    begin
        sync_meta <= {scl, sda_i, output_enable_n,
                      addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, port_pin_i};
        sync_q <= sync_meta;
    end

    assign pin_level = sync_q[PIN_COUNT-1:0];
    assign strap_level = sync_q[PIN_COUNT +: STRAP_COUNT];
    assign oe_n_s = sync_q[PIN_COUNT + STRAP_COUNT];
    assign sda_s = sync_q[PIN_COUNT + STRAP_COUNT + 1];
    assign scl_s = sync_q[PIN_COUNT + STRAP_COUNT + 2];

    always_comb
    begin
        for (int b = 0; b < BANK_COUNT; b++)
        begin
            pin_bank[b] = pin_level[b*BANK_WIDTH +: BANK_WIDTH];
            input_level_regs[b] = pin_bank[b] ^ read_invert_regs[b];
        end
    end

    // Start and stop framing
    assign bus_start = scl_s & sda_prev & ~sda_s;
    assign bus_stop = scl_s & ~sda_prev & sda_s;

    always_ff @(posedge clk)
    begin
        sda_prev <= sda_s;
    end

    // Clear is held until the clock goes low, so the link leaves reset between edges
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            frame_clr <= 1'b1;
        else if (bus_start || bus_stop)
            frame_clr <= 1'b1;
        else if (!scl_s && evt_sync == 2'b00)
            frame_clr <= 1'b0;
    end

    // Event toggles from the link
    always_ff @(posedge clk)
    begin
        evt_meta <= {lnk.evt_tog, lnk.wr_tog};
        evt_sync <= evt_meta;
        evt_prev <= evt_sync;
    end

    // Toggles fall back to zero during a clear; those edges are not events
    assign cmd_fire = (evt_sync[1] ^ evt_prev[1]) & ~frame_clr & (lnk.evt_kind == EVT_CMD);
    assign rd_fire = (evt_sync[1] ^ evt_prev[1]) & ~frame_clr & (lnk.evt_kind == EVT_RD_START);
    assign rd_next_fire = (evt_sync[1] ^ evt_prev[1]) & ~frame_clr
                          & (lnk.evt_kind == EVT_RD_NEXT);
    assign wr_fire = (evt_sync[0] ^ evt_prev[0]) & ~frame_clr;

    function automatic logic [7:0] step_pointer(input logic [7:0] p);
        logic [7:0] result;
        result = p;
        if (p[STEP_FLAG_BIT])
        begin
            if (p[BANK_MSB:0] >= LAST_BANK)
                result = {p[7:BANK_MSB+1], 3'h0};
            else
                result = {p[7:BANK_MSB+1], p[BANK_MSB:0] + 3'h1};
        end
        return result;
    endfunction

    function automatic logic bank_ok(input logic [7:0] p);
        return p[BANK_MSB:0] <= LAST_BANK;
    endfunction

    // Reserved and undefined codes read as zero and ignore writes
    function automatic logic [7:0] read_register(input logic [7:0] p);
        logic [2:0] bank;
        logic [2:0] group;
        logic [7:0] value;
        bank = p[BANK_MSB:0];
        group = p[GROUP_MSB:GROUP_LSB];
        value = 8'h00;
        if (!bank_ok(p))
            value = 8'h00;
        else if (group == INPUT_BASE[GROUP_MSB:GROUP_LSB])
            value = input_level_regs[bank];
        else if (group == OUTPUT_BASE[GROUP_MSB:GROUP_LSB])
            value = output_drive_regs[bank];
        else if (group == INVERT_BASE[GROUP_MSB:GROUP_LSB])
            value = read_invert_regs[bank];
        else if (group == DIRECTION_BASE[GROUP_MSB:GROUP_LSB])
            value = direction_regs[bank];
        else if (group == MASK_BASE[GROUP_MSB:GROUP_LSB])
            value = change_mask_regs[bank];
        return value;
    endfunction

    // Command pointer
    always_comb
    begin
        next_command_pointer = command_pointer;
        if (cmd_fire)
            next_command_pointer = lnk.evt_byte;
        else if (wr_fire || rd_next_fire)
            next_command_pointer = step_pointer(command_pointer);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            command_pointer <= POINTER_RESET;
        else
            command_pointer <= next_command_pointer;
    end

    // Register writes, applied during the acknowledge of the data byte
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int b = 0; b < BANK_COUNT; b++)
            begin
                output_drive_regs[b] <= OUTPUT_RESET;
                read_invert_regs[b] <= INVERT_RESET;
                direction_regs[b] <= DIRECTION_RESET;
                change_mask_regs[b] <= MASK_RESET;
            end
        end
        else if (wr_fire && bank_ok(command_pointer))
        begin
            if (command_pointer[GROUP_MSB:GROUP_LSB] == OUTPUT_BASE[GROUP_MSB:GROUP_LSB])
                output_drive_regs[command_pointer[BANK_MSB:0]] <= lnk.wr_byte;
            else if (command_pointer[GROUP_MSB:GROUP_LSB] == INVERT_BASE[GROUP_MSB:GROUP_LSB])
                read_invert_regs[command_pointer[BANK_MSB:0]] <= lnk.wr_byte;
            else if (command_pointer[GROUP_MSB:GROUP_LSB]
                     == DIRECTION_BASE[GROUP_MSB:GROUP_LSB])
                direction_regs[command_pointer[BANK_MSB:0]] <= lnk.wr_byte;
            else if (command_pointer[GROUP_MSB:GROUP_LSB] == MASK_BASE[GROUP_MSB:GROUP_LSB])
                change_mask_regs[command_pointer[BANK_MSB:0]] <= lnk.wr_byte;
        end
    end

    // Read snapshot is refreshed one cycle after an event, once the pointer settled
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            snap_req <= 1'b0;
            snap_rd <= 1'b0;
        end
        else
        begin
            snap_req <= cmd_fire | rd_fire | rd_next_fire | wr_fire;
            snap_rd <= rd_fire | rd_next_fire;
        end
    end

    // The byte stays put between events, so the link may sample it without a handshake
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            read_snapshot <= 8'h00;
            wr_refused <= (POINTER_RESET[GROUP_MSB:GROUP_LSB]
                           == INPUT_BASE[GROUP_MSB:GROUP_LSB]);
        end
        else if (snap_req)
        begin
            read_snapshot <= read_register(command_pointer);
            wr_refused <= (command_pointer[GROUP_MSB:GROUP_LSB]
                           == INPUT_BASE[GROUP_MSB:GROUP_LSB]);
        end
    end

    // Levels last handed to the master; the first cycle after reset takes the pins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            primed <= 1'b0;
            for (int b = 0; b < BANK_COUNT; b++)
                last_read[b] <= 8'h00;
        end
        else if (!primed)
        begin
            primed <= 1'b1;
            for (int b = 0; b < BANK_COUNT; b++)
                last_read[b] <= pin_bank[b];
        end
        else if (snap_rd && bank_ok(command_pointer)
                 && command_pointer[GROUP_MSB:GROUP_LSB] == INPUT_BASE[GROUP_MSB:GROUP_LSB])
        begin
            last_read[command_pointer[BANK_MSB:0]] <= pin_bank[command_pointer[BANK_MSB:0]];
        end
    end

    // Change is level based: a pin returning to its read level releases the alert
    always_comb
    begin
        change_seen = 1'b0;
        for (int b = 0; b < BANK_COUNT; b++)
            change_seen = change_seen
                          | (|((pin_bank[b] ^ last_read[b])
                               & ~change_mask_regs[b] & direction_regs[b]));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            alert <= 1'b0;
        else
            alert <= primed & change_seen;
    end

    // Port pins
    always_comb
    begin
        for (int b = 0; b < BANK_COUNT; b++)
        begin
            port_pin_o[b*BANK_WIDTH +: BANK_WIDTH] = output_drive_regs[b];
            port_pin_oe_n[b*BANK_WIDTH +: BANK_WIDTH] = direction_regs[b]
                                                       | {BANK_WIDTH{oe_n_s}};
        end
    end

    // Link side of the core
    assign lnk.rd_byte = read_snapshot;
    assign lnk.wr_refused = wr_refused;
    assign lnk.strap = strap_level;

    // Open-drain outputs only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_n = ~lnk.sda_low;
    assign alert_o = 1'b0;
    assign alert_oe_n = ~alert;

endmodule // gpio_expander

//--- logic/link_if.sv
`timescale 1ns/1ps
interface link_if;
    import gpio_exp_pkg::*;
    logic evt_tog;
    link_evt_t evt_kind;
    logic [7:0] evt_byte;
    logic wr_tog;
    logic [7:0] wr_byte;
    logic sda_low;
    logic [7:0] rd_byte;
    logic wr_refused;
    logic [STRAP_COUNT-1:0] strap;

    modport link (
        output evt_tog, evt_kind, evt_byte, wr_tog, wr_byte, sda_low,
        input rd_byte, wr_refused, strap
    );

    modport core (
        input evt_tog, evt_kind, evt_byte, wr_tog, wr_byte, sda_low,
        output rd_byte, wr_refused, strap
    );
endinterface

//--- logic/serial_slave.sv
`timescale 1ns/1ps
module serial_slave
    import gpio_exp_pkg::*;
#(
    parameter logic [3:0] SLAVE_ADDR_HI = SLAVE_ADDR_HI_DEFAULT
)
(
    // Serial link
    input wire logic scl,
    input wire logic sda_i,
    // Frame boundary clear from the core
    input wire logic frame_clr,
    // Core side
    link_if.link lnk
);

    link_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [7:0] rx_byte;
    logic parked;

    assign rx_byte = {shift_in[6:0], sda_i};

    // Data is sampled on the rising edge of the link clock
    always_ff @(posedge scl or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            state <= LS_ADDR;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            lnk.evt_tog <= 1'b0;
            lnk.evt_kind <= EVT_CMD;
            lnk.evt_byte <= 8'h00;
            parked <= 1'b0;
        end
        else
        begin
            bit_cnt <= bit_cnt + 3'h1;
            shift_in <= rx_byte;
            case (state)
                LS_ADDR:
                    if (bit_cnt == 3'h7)
                    begin
                        if (rx_byte[7:1] == {SLAVE_ADDR_HI, lnk.strap})
                        begin
                            state <= LS_ADDR_ACK;
                            if (rx_byte[0])
                            begin
                                lnk.evt_kind <= EVT_RD_START;
                                lnk.evt_tog <= ~lnk.evt_tog;
                            end
                        end
                        else
                        begin
                            state <= LS_RD_ACK;
                            parked <= 1'b1;
                        end
                    end
                LS_ADDR_ACK:
                begin
                    bit_cnt <= 3'h0;
                    state <= shift_in[0] ? LS_RD : LS_CMD;
                end
                LS_CMD:
                    if (bit_cnt == 3'h7)
                    begin
                        lnk.evt_kind <= EVT_CMD;
                        lnk.evt_byte <= rx_byte;
                        lnk.evt_tog <= ~lnk.evt_tog;
                        state <= LS_CMD_ACK;
                    end
                LS_CMD_ACK, LS_WR_ACK:
                begin
                    bit_cnt <= 3'h0;
                    state <= LS_WR;
                end
                LS_WR:
                    if (bit_cnt == 3'h7)
                        state <= LS_WR_ACK;
                LS_RD:
                    if (bit_cnt == 3'h7)
                    begin
                        lnk.evt_kind <= EVT_RD_NEXT;
                        lnk.evt_tog <= ~lnk.evt_tog;
                        state <= LS_RD_ACK;
                    end
                LS_RD_ACK:
                begin
                    // A not-acknowledge, or a foreign address, parks here until the frame ends
                    bit_cnt <= 3'h0;
                    // Once parked, low bits of later traffic must not restart a read
                    if (!parked && !sda_i && bit_cnt == 3'h0)
                        state <= LS_RD;
                    else
                        parked <= 1'b1;
                end
                default:
                    state <= LS_ADDR;
            endcase
        end
    end

    // Data is driven on the falling edge so it is stable before the next rise
    always_ff @(negedge scl or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            lnk.sda_low <= 1'b0;
            lnk.wr_tog <= 1'b0;
            lnk.wr_byte <= 8'h00;
            shift_out <= 8'h00;
        end
        else
        begin
            case (state)
                LS_ADDR_ACK, LS_CMD_ACK:
                    lnk.sda_low <= 1'b1;
                LS_WR_ACK:
                begin
                    lnk.sda_low <= ~lnk.wr_refused;
                    if (!lnk.wr_refused)
                    begin
                        lnk.wr_byte <= shift_in;
                        lnk.wr_tog <= ~lnk.wr_tog;
                    end
                end
                LS_RD:
                    if (bit_cnt == 3'h0)
                    begin
                        lnk.sda_low <= ~lnk.rd_byte[7];
                        shift_out <= {lnk.rd_byte[6:0], 1'b0};
                    end
                    else
                    begin
                        lnk.sda_low <= ~shift_out[7];
                        shift_out <= {shift_out[6:0], 1'b0};
                    end
                default:
                    lnk.sda_low <= 1'b0;
            endcase
        end
    end

endmodule // serial_slave

//--- tb/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model
(
    // Serial wire
    output logic scl,
    input wire logic sda,
    output logic sda_low
);
    // Quarter of the 125 ns bit; the clock stands high between frames
    localparam realtime QTR = 31.25;

    initial scl = 1'b1;
    initial sda_low = 1'b0;

    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        #QTR;
        scl = 1'b1;
        #QTR;
        r = sda;
        #QTR;
        scl = 1'b0;
        #QTR;
    endtask

    // Also a repeated start; data falls only while the clock is high
    task automatic start_cond();
        sda_low = 1'b0;
        #QTR;
        scl = 1'b1;
        #(2 * QTR);
        sda_low = 1'b1;
        #(2 * QTR);
        scl = 1'b0;
        #QTR;
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        #QTR;
        scl = 1'b1;
        #(2 * QTR);
        sda_low = 1'b0;
        #(4 * QTR);
    endtask

    // Eight bits out and back, then the ninth: last high releases for the device
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r,
        output logic ack_bit);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r[i]);
        end
        bit_io(last, ack_bit);
    endtask
endmodule // bus_master_model

//--- tb/gpio_expander_asserts.sv
`timescale 1ns/1ps
module gpio_expander_asserts
    import gpio_exp_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    input wire logic scl,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    // Pins and alert
    input wire logic output_enable_n,
    input wire logic [PIN_COUNT-1:0] port_pin_o,
    input wire logic [PIN_COUNT-1:0] port_pin_oe_n,
    input wire logic alert_o,
    input wire logic alert_oe_n
);
    // Recent enable samples; the enable reaches the pins through a two-flop sync
    logic [3:0] oe_hist;

    always_ff @(posedge clk)
    begin
        oe_hist <= {oe_hist[2:0], output_enable_n};
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence oe_high_run;
        output_enable_n[*4];
    endsequence

    // Longer than the clock-high phase of any data bit within a frame
    sequence bus_idle_run;
        scl[*8];
    endsequence

    a_reset_defaults: assert property (
        $rose(rst_n) |-> &port_pin_oe_n && alert_oe_n && port_pin_o == '0)
        else $error("pins not at defaults after reset");
    a_oe_floats_out: assert property (oe_high_run |-> &port_pin_oe_n)
        else $error("output pin driven while enable high");
    a_alert_open_drain: assert property (alert_o == 1'b0 && sda_o == 1'b0)
        else $error("open-drain data not low");
    a_ack_starts_low: assert property ($fell(sda_oe_n) |-> !scl)
        else $error("data line pulled while clock high");
    a_ack_ends_low: assert property ($rose(sda_oe_n) |-> !scl)
        else $error("data line released while clock high");
    a_idle_bus_free: assert property (bus_idle_run |-> sda_oe_n)
        else $error("data line held on idle bus");
    a_drive_at_ack: assert property ($changed(port_pin_o) |-> !sda_oe_n)
        else $error("output level moved outside acknowledge");
    a_dir_at_ack: assert property (
        $changed(port_pin_oe_n) |-> !sda_oe_n || oe_hist != {4{output_enable_n}})
        else $error("pin direction moved without cause");
endmodule // gpio_expander_asserts

bind gpio_expander gpio_expander_asserts chk (
    .clk(clk),
    .rst_n(rst_n),
    .scl(scl),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .output_enable_n(output_enable_n),
    .port_pin_o(port_pin_o),
    .port_pin_oe_n(port_pin_oe_n),
    .alert_o(alert_o),
    .alert_oe_n(alert_oe_n)
);

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("[ERR] %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module tb
    import gpio_exp_pkg::*;
;
    localparam logic [PIN_COUNT-1:0] PINS_A = 40'h9a_78_56_34_12;
    logic clk = 1'b0;
    logic rst_n;
    logic [2:0] strap;
    logic output_enable_n;
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] pin_o;
    logic [PIN_COUNT-1:0] pin_oe_n;
    logic scl, m_low, sda_o, sda_oe_n, alert_o, alert_oe_n;
    logic [7:0] got;
    logic [7:0] e;
    logic nack;
    int error_cnt = 0;
    int checks_done = 0;
    // Pulled-up data wire, low if either party pulls
    wire sda_line = !(m_low || (!sda_oe_n && !sda_o));

    always #5 clk = ~clk;

    gpio_expander dut (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .output_enable_n(output_enable_n), .port_pin_i(pins),
        .port_pin_o(pin_o), .port_pin_oe_n(pin_oe_n), .alert_o(alert_o),
        .alert_oe_n(alert_oe_n));
    bus_master_model m (.scl(scl), .sda(sda_line), .sda_low(m_low));

    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic addr_cmd(input logic [7:0] cmd);
        m.start_cond();
        m.byte_io({SLAVE_ADDR_HI_DEFAULT, strap, 1'b0}, 1'b1, got, nack);
        m.byte_io(cmd, 1'b1, got, nack);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
        addr_cmd(cmd);
        foreach (d[i])
        begin
            m.byte_io(d[i], 1'b1, got, nack);
        end
        m.stop_cond();
    endtask

    // All-ones command keeps the pointer as it stands
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp[$]);
        if (cmd != 8'hff)
            addr_cmd(cmd);
        m.start_cond();
        m.byte_io({SLAVE_ADDR_HI_DEFAULT, strap, 1'b1}, 1'b1, got, nack);
        foreach (exp[i])
        begin
            m.byte_io(8'hff, i == exp.size() - 1, got, nack);
            `CHK(got, exp[i]);
        end
        m.stop_cond();
    endtask

    task automatic probe(input logic [2:0] low, input logic exp_nack);
        m.start_cond();
        m.byte_io({SLAVE_ADDR_HI_DEFAULT, low, 1'b0}, 1'b1, got, nack);
        m.stop_cond();
        `CHK(nack, exp_nack);
    endtask

    initial
    begin
        rst_n = 1'b0;
        strap = 3'h5;
        output_enable_n = 1'b0;
        pins = PINS_A;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(8'hff, {8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'h12});
        for (int g = 1; g < 5; g++)
        begin
            e = (g >= 3) ? 8'hff : 8'h00;
            rd(8'h80 | 8'(g * 8), {e, e, e, e, e});
        end
        for (int s = 0; s < 8; s++)
        begin
            @(posedge clk);
            strap <= 3'(s);
            repeat (4) @(posedge clk);
            probe(3'(s), 1'b0);
            probe(3'(s) ^ 3'h7, 1'b1);
        end
        wr(8'h88, {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
        `CHK(nack, 1'b0);
        wr(8'h98, {8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        `CHK(pin_o, 40'h55_44_33_22_66);
        `CHK(pin_oe_n, 40'h00_00_00_00_00);
        rd(8'h88, {8'h66, 8'h22, 8'h33, 8'h44, 8'h55});
        wr(8'h0a, {8'ha5, 8'h5a});
        rd(8'h0a, {8'h5a, 8'h5a});
        `CHK(pin_o, 40'h55_44_5a_22_66);
        wr(8'h81, {8'hee});
        `CHK(nack, 1'b1);
        rd(8'h01, {8'h34, 8'h34});
        wr(8'h90, {8'hff, 8'h0f});
        rd(8'h80, {8'hed, 8'h3b, 8'h56});
        wr(8'h1b, {8'h0f});
        @(posedge clk);
        output_enable_n <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(pin_oe_n, {PIN_COUNT{1'b1}});
        output_enable_n <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK(pin_oe_n, 40'h00_0f_00_00_00);
        wr(8'h18, {8'hff});
        wr(8'h20, {8'hfe});
        rd(8'h00, {8'hed});
        @(posedge clk);
        // Pin 1 is masked, pin 0 is not: alert follows pin 0 only
        for (int k = 0; k < 4; k++)
        begin
            pins <= PINS_A ^ ((k % 2) ? 40'h3 : 40'h2);
            repeat (8) @(posedge clk);
            `CHK(alert_oe_n, !(k % 2));
        end
        rd(8'h00, {8'hee});
        `CHK(alert_oe_n, 1'b1);
        // Second reset in mid-run: everything back to defaults, pins stay as they are
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(pin_oe_n, {PIN_COUNT{1'b1}});
        `CHK(pin_o, {PIN_COUNT{1'b0}});
        `CHK(alert_oe_n, 1'b1);
        rd(8'hff, {8'h11});
        give_verdict();
    end

    // The tests take about 16k cycles
    initial
    begin
        #400000;
        error_cnt++;
        give_verdict();
    end
endmodule // tb
